// [pach_pkg.sv]
// Shared constants for the parameter access command handler.
// Assumes one 25 MHz core clock and a synchronous, active high reset.
package pach_pkg;

   // ******************************************************
   // Frame layout
   // ******************************************************
   localparam int FRAME_BYTES = 9; // Address, instr, type, bank, 4 value bytes, checksum
   localparam logic [3:0] POS_ADDR = 4'h0; // Target address byte
   localparam logic [3:0] POS_INSTR = 4'h1; // Instruction byte
   localparam logic [3:0] POS_TYPE = 4'h2; // Parameter number byte
   localparam logic [3:0] POS_BANK = 4'h3; // Motor or bank byte
   localparam logic [3:0] POS_VAL3 = 4'h4; // Most significant value byte
   localparam logic [3:0] POS_SUM = 4'h8; // Checksum byte, last of the frame
   localparam logic [7:0] DEV_ADDR_RST = 8'h01; // Default target address

   // ******************************************************
   // Instructions
   // ******************************************************
   localparam logic [7:0] INS_AXIS_SET = 8'h05; // axis_param_set
   localparam logic [7:0] INS_AXIS_GET = 8'h06; // axis_param_get
   localparam logic [7:0] INS_AXIS_STORE = 8'h07; // axis_param_store
   localparam logic [7:0] INS_AXIS_RESTORE = 8'h08; // axis_param_restore
   localparam logic [7:0] INS_GLOBAL_SET = 8'h09; // global_param_set
   localparam logic [7:0] INS_GLOBAL_GET = 8'h0A; // global_param_get
   localparam logic [7:0] INS_GLOBAL_STORE = 8'h0B; // global_param_store

   // ******************************************************
   // Banks, parameter space and status codes
   // ******************************************************
   localparam logic [7:0] BANK_SETTINGS = 8'h00; // Module settings, saved on every write
   localparam logic [7:0] BANK_USER = 8'h02; // User variables
   localparam logic [7:0] BANK_IRQ = 8'h03; // Interrupt configuration
   localparam logic [7:0] AXIS_MOTOR = 8'h00; // Only motor 0 exists
   localparam int PARAM_COUNT = 16; // Parameters held per table
   localparam logic [3:0] PARAM_LAST = 4'hF; // Highest parameter number
   localparam logic [7:0] ST_OK = 8'h64; // Success status, 100
   localparam logic [7:0] ST_BAD_SUM = 8'h01; // Checksum mismatch
   localparam logic [7:0] ST_BAD_CMD = 8'h02; // Unknown instruction
   localparam logic [7:0] ST_BAD_TYPE = 8'h03; // Parameter number out of range
   localparam logic [7:0] ST_BAD_BANK = 8'h04; // Motor or bank not supported
   localparam logic [31:0] VAL_ZERO = 32'h0000_0000; // Reply value for store and restore

   // Handler states
   typedef enum logic [1:0] {PACH_BOOT, PACH_RX, PACH_EXEC} pach_state_t;

endpackage

// [pach_top.sv]
// Parameter access command handler: takes nine-byte frames, keeps the axis
// and global parameter tables and stored copies of all but bank 3, answers each frame sent to its address.
// Assumes frame bytes come from logic on the same clock (a UART receiver) and
// that a reply consumer takes the one-cycle reply strobe.
`timescale 1ns/1ps

module pach_top #(
   parameter logic [7:0] DEV_ADDR = pach_pkg::DEV_ADDR_RST // Target address answered
) (
   input wire logic mclk_in, // Core clock, 25 MHz
   input wire logic rst_in, // Synchronous reset, active high
   input wire logic [7:0] byte_in, // Frame byte from the command link
   input wire logic byte_valid_in, // One-cycle strobe with byte_in
   input wire logic standalone_in, // High while a stored program runs
   output logic ready_out, // High while frame bytes are taken
   output logic reply_valid_out, // One-cycle reply strobe
   output logic [7:0] reply_status_out, // Reply status
   output logic [31:0] reply_value_out, // Reply value
   output logic [31:0] accu_out // Accumulator
);
   import pach_pkg::*;

   // ******************************************************
   // State
   // ******************************************************
   typedef logic [PARAM_COUNT-1:0][31:0] pach_table_t;

   typedef struct packed {
      pach_state_t st; // Handler state
      logic [3:0] cnt; // Frame byte count, also boot index
      logic [FRAME_BYTES-1:0][7:0] fr; // Frame bytes, address first
      logic [7:0] sum; // Running sum of bytes taken so far
      pach_table_t axis; // Axis working values, volatile
      pach_table_t glob0; // Bank 0 module settings
      pach_table_t glob2; // Bank 2 user variables
      pach_table_t glob3; // Bank 3 interrupt configuration
      logic [31:0] accu; // Accumulator
      logic rdy; // Byte acceptance
      logic rvld; // Reply strobe
      logic [7:0] rstat; // Reply status
      logic [31:0] rval; // Reply value
   } pach_regs_t;

   pach_regs_t r; // Registered state
   pach_regs_t next_r; // Next state

   // Nonvolatile copies; never reset, they outlive rst_in like the real store
   logic [31:0] nv_axis [PARAM_COUNT]; // Stored axis parameters
   logic [31:0] nv_glob0 [PARAM_COUNT]; // Stored module settings
   logic [31:0] nv_glob2 [PARAM_COUNT]; // Stored user variables

   // Write strobes into the nonvolatile copies
   logic nv_axis_we; // Axis store
   logic nv_glob0_we; // Bank 0 auto save
   logic nv_glob2_we; // User variable store
   logic [3:0] nv_idx; // Parameter written
   logic [31:0] nv_data; // Value written

   // Decoded frame fields
   logic [7:0] f_instr; // Instruction
   logic [7:0] f_type; // Parameter number
   logic [7:0] f_bank; // Motor or bank
   logic [31:0] f_val; // Value, most significant byte first
   logic [3:0] pidx; // Parameter index

   // Parameter number in range of the tables
   function automatic logic type_ok(input logic [7:0] t);
      type_ok = (t[7:4] == 4'h0) && (t[3:0] <= PARAM_LAST);
   endfunction

   // Global bank is one of the three held here
   function automatic logic bank_ok(input logic [7:0] b);
      bank_ok = (b == BANK_SETTINGS) || (b == BANK_USER) || (b == BANK_IRQ);
   endfunction

   // Field extraction from the held frame
   always_comb begin
      f_instr = r.fr[POS_INSTR];
      f_type = r.fr[POS_TYPE];
      f_bank = r.fr[POS_BANK];
      f_val = {r.fr[POS_VAL3], r.fr[POS_VAL3+4'h1], r.fr[POS_VAL3+4'h2], r.fr[POS_VAL3+4'h3]};
      pidx = f_type[3:0];
   end

   // ******************************************************
   // Next state
   // ******************************************************
   always_comb begin
      next_r = r;
      next_r.rvld = 1'b0;
      nv_axis_we = 1'b0;
      nv_glob0_we = 1'b0;
      nv_glob2_we = 1'b0;
      nv_idx = pidx;
      nv_data = VAL_ZERO;
      case (r.st)
         PACH_BOOT: begin
            // Axis, bank 0 and bank 2 tables load from their stored copies before any frame is taken; bank 3 keeps its reset zeros
            next_r.axis[r.cnt] = nv_axis[r.cnt];
            next_r.glob0[r.cnt] = nv_glob0[r.cnt];
            next_r.glob2[r.cnt] = nv_glob2[r.cnt];
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == PARAM_LAST) begin
               next_r.st = PACH_RX;
               next_r.cnt = 4'h0;
               next_r.rdy = 1'b1;
            end
         end
         PACH_RX: begin
            // Bytes gather in order; the ninth closes the frame
            if (byte_valid_in) begin
               next_r.fr[r.cnt] = byte_in;
               next_r.sum = r.sum + byte_in;
               next_r.cnt = r.cnt + 4'h1;
               if (r.cnt == POS_SUM) begin
                  next_r.st = PACH_EXEC;
                  next_r.rdy = 1'b0; // Link is deaf while the frame executes
               end
            end
         end
         PACH_EXEC: begin
            next_r.st = PACH_RX;
            next_r.cnt = 4'h0;
            next_r.sum = 8'h00;
            next_r.rdy = 1'b1;
            // Frames for other addresses pass silently
            if (r.fr[POS_ADDR] == DEV_ADDR) begin
               next_r.rvld = 1'b1;
               next_r.rstat = ST_OK;
               next_r.rval = VAL_ZERO;
               // Sum excludes the checksum byte itself
               if ((r.sum - r.fr[POS_SUM]) != r.fr[POS_SUM]) begin
                  next_r.rstat = ST_BAD_SUM;
               end else if (f_instr < INS_AXIS_SET || f_instr > INS_GLOBAL_STORE) begin
                  next_r.rstat = ST_BAD_CMD;
               end else if (!type_ok(f_type)) begin
                  next_r.rstat = ST_BAD_TYPE;
               end else if (f_instr <= INS_AXIS_RESTORE) begin
                  if (f_bank != AXIS_MOTOR) begin
                     next_r.rstat = ST_BAD_BANK;
                  end else begin
                     case (f_instr)
                        INS_AXIS_SET: begin
                           next_r.axis[pidx] = f_val;
                        end
                        INS_AXIS_GET: begin
                           next_r.rval = r.axis[pidx];
                           if (standalone_in) begin
                              next_r.accu = r.axis[pidx];
                           end
                           // Direct mode leaves the accumulator as it was
                        end
                        INS_AXIS_STORE: begin
                           nv_axis_we = 1'b1;
                           nv_data = r.axis[pidx];
                        end
                        default: begin
                           next_r.axis[pidx] = nv_axis[pidx];
                        end
                     endcase
                  end
               end else if (!bank_ok(f_bank)) begin
                  next_r.rstat = ST_BAD_BANK;
               end else begin
                  case (f_instr)
                     INS_GLOBAL_SET: begin
                        // Bank select
                        case (f_bank)
                           BANK_SETTINGS: begin
                              next_r.glob0[pidx] = f_val;
                              nv_glob0_we = 1'b1;
                              nv_data = f_val;
                           end
                           BANK_USER: begin
                              next_r.glob2[pidx] = f_val;
                           end
                           default: begin
                              next_r.glob3[pidx] = f_val;
                           end
                        endcase
                     end
                     INS_GLOBAL_GET: begin
                        case (f_bank)
                           BANK_SETTINGS: next_r.rval = r.glob0[pidx];
                           BANK_USER: next_r.rval = r.glob2[pidx];
                           default: next_r.rval = r.glob3[pidx];
                        endcase
                        next_r.accu = next_r.rval;
                     end
                     default: begin
                        // Only user variables have a store of their own
                        if (f_bank == BANK_USER) begin
                           nv_glob2_we = 1'b1;
                           nv_data = r.glob2[pidx];
                        end else begin
                           next_r.rstat = ST_BAD_BANK;
                        end
                     end
                  endcase
               end
            end
         end
         default: begin
            next_r.st = PACH_BOOT;
         end
      endcase
   end

   // ******************************************************
   // Registers
   // ******************************************************
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         r <= '0;
         r.st <= PACH_BOOT;
      end else begin
         r <= next_r;
      end
   end

   // Nonvolatile copies take writes only on a good frame
   always_ff @(posedge mclk_in) begin
      if (nv_axis_we) begin
         nv_axis[nv_idx] <= nv_data;
      end
      if (nv_glob0_we) begin
         nv_glob0[nv_idx] <= nv_data;
      end
      if (nv_glob2_we) begin
         nv_glob2[nv_idx] <= nv_data;
      end
   end

   // Outputs straight from the state register
   assign ready_out = r.rdy;
   assign reply_valid_out = r.rvld;
   assign reply_status_out = r.rstat;
   assign reply_value_out = r.rval;
   assign accu_out = r.accu;

   // ******************************************************
   // Checks
   // ******************************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   a_frame_reply:
   assert property ((r.st == PACH_RX) && byte_valid_in && (r.cnt == POS_SUM)
      |=> ((r.st == PACH_EXEC) && !ready_out) ##1 (reply_valid_out == (r.fr[POS_ADDR] == DEV_ADDR)))
      else $error("frame did not reach execution");

   a_set_writes:
   assert property ((r.st == PACH_EXEC) && reply_valid_out == 1'b0 && (r.fr[POS_ADDR] == DEV_ADDR)
      ##0 (next_r.rstat == ST_OK) && (f_instr == INS_AXIS_SET)
      |=> (r.axis[$past(pidx)] == $past(f_val)) && reply_valid_out && (reply_status_out == ST_OK))
      else $error("axis set did not take the value");

   a_get_value:
   assert property ((r.st == PACH_EXEC) && (next_r.rstat == ST_OK) && next_r.rvld && (f_instr == INS_AXIS_GET)
      |=> reply_value_out == $past(r.axis[pidx]))
      else $error("axis get returned a wrong value");

   a_accu_direct:
   assert property ((r.st == PACH_EXEC) && !standalone_in && (f_instr == INS_AXIS_GET)
      |=> $stable(accu_out))
      else $error("direct axis get changed the accumulator");

   a_accu_standalone:
   assert property ((r.st == PACH_EXEC) && standalone_in && next_r.rvld && (next_r.rstat == ST_OK)
      && (f_instr == INS_AXIS_GET) |=> accu_out == reply_value_out)
      else $error("standalone axis get missed the accumulator");

   a_store_zero:
   assert property (reply_valid_out && (reply_status_out == ST_OK)
      && ($past(f_instr) == INS_AXIS_STORE || $past(f_instr) == INS_AXIS_RESTORE)
      |-> reply_value_out == VAL_ZERO)
      else $error("store or restore replied nonzero");

   a_bank0_save:
   assert property (nv_glob0_we |-> (f_bank == BANK_SETTINGS) && (f_instr == INS_GLOBAL_SET)
      ##1 (nv_glob0[$past(nv_idx)] == r.glob0[$past(nv_idx)]))
      else $error("bank 0 write not saved");

   a_error_quiet:
   assert property ((r.st == PACH_EXEC) && next_r.rvld && (next_r.rstat != ST_OK)
      |=> $stable(r.axis) && $stable(r.glob0) && $stable(r.glob2) && $stable(r.glob3) && $stable(accu_out))
      else $error("rejected frame changed state");

   a_boot_length:
   // Ready stays low through boot index 15 and is seen high at the seventeenth edge after release
   assert property ($fell(rst_in) |-> !ready_out [*8] ##8 !ready_out ##1 ready_out)
      else $error("boot load did not take sixteen cycles");

endmodule // pach_top

// [pach_host.sv]
// Host model for the parameter access command handler: sends nine-byte frames.
// Assumes it shares the handler's core clock and that ready_in is the handler's ready.
`timescale 1ns/1ps

module pach_host (
   input wire logic mclk_in, // Core clock
   input wire logic ready_in, // Handler takes bytes while high
   output logic [7:0] byte_out, // Frame byte
   output logic byte_valid_out // One-cycle strobe per byte
);
   // ******************************************************
   // Idle line
   // ******************************************************
   // Data line has no pull: A5 at start, the inverse of the last byte after a frame, and flipped each cycle only while a frame waits
   initial begin
      byte_out = 8'hA5;
      byte_valid_out = 1'b0;
   end

   // ******************************************************
   // Frame sender
   // ******************************************************
   // Entered at a falling edge; bytes change only on falling edges
   task automatic send_frame(input logic [71:0] frame, input int axis_param_get, output bit ok);
      int i;
      int tries;
      ok = 1'b1;
      for (i = 0; i < 9; i++) begin
         // Optional slow host: idle cycles between bytes
         repeat (axis_param_get) begin
            byte_valid_out = 1'b0;
            byte_out = ~byte_out;
            @(negedge mclk_in);
         end
         // Wait up to 40 cycles for ready; on timeout ok clears and the byte is offered anyway
         tries = 0;
         while (ready_in !== 1'b1 && tries < 40) begin
            byte_valid_out = 1'b0;
            byte_out = ~byte_out;
            @(negedge mclk_in);
            tries++;
         end
         if (tries >= 40) begin
            ok = 1'b0;
         end
         byte_out = frame[71-8*i -: 8];
         byte_valid_out = 1'b1;
         @(negedge mclk_in);
      end
      // Release; caller waits for the reply before the next frame
      byte_valid_out = 1'b0;
      byte_out = ~byte_out;
   endtask
endmodule // pach_host

// [pach_top_tb.sv]
// Self-checking bench for the parameter access command handler.
// Assumes the host model drives the byte port; the bench drives reset and mode.
`timescale 1ns/1ps

module pach_top_tb;
   import pach_pkg::*;

   // ******************************************************
   // Signals and instances
   // ******************************************************
   logic mclk_in = 1'b0; // Core clock
   logic rst_in = 1'b1; // Synchronous reset
   logic standalone_in = 1'b0; // Direct mode first
   logic [7:0] byte_in; // From host model
   logic byte_valid_in; // From host model
   logic ready_out;
   logic reply_valid_out;
   logic [7:0] reply_status_out;
   logic [31:0] reply_value_out;
   logic [31:0] accu_out;
   int fails = 0; // Mismatch count
   int check_count = 0; // Comparison count
   localparam logic [7:0] A = DEV_ADDR_RST; // Address answered
   localparam logic [7:0] ANY_ERR = 8'hFF; // Any non-success status

   always #20 mclk_in = ~mclk_in; // 25 MHz

   pach_top pach_top_inst (.mclk_in(mclk_in), .rst_in(rst_in), .byte_in(byte_in),
      .byte_valid_in(byte_valid_in), .standalone_in(standalone_in), .ready_out(ready_out),
      .reply_valid_out(reply_valid_out), .reply_status_out(reply_status_out),
      .reply_value_out(reply_value_out), .accu_out(accu_out));
   pach_host pach_host_inst (.mclk_in(mclk_in), .ready_in(ready_out), .byte_out(byte_in),
      .byte_valid_out(byte_valid_in));

   // ******************************************************
   // Shared tasks
   // ******************************************************
   // Single exit point of the run
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask

   // Reset for four cycles, then wait out the table load
   task automatic boot;
      int n;
      rst_in = 1'b1;
      repeat (4) @(negedge mclk_in);
      rst_in = 1'b0;
      chk("accu after reset", 32'h0, accu_out);
      n = 0;
      while (ready_out !== 1'b1 && n < 40) begin
         @(negedge mclk_in);
         n++;
      end
      chk("boot load length", 32'd16, n);
      if (n >= 40) begin
         summarize();
      end
   endtask

   // One frame, then judge the reply; est 0 means no reply is expected
   task automatic cmd(input logic [7:0] adr, input logic [7:0] ins, input logic [7:0] typ,
      input logic [7:0] bnk, input logic [31:0] val, input logic [7:0] sumx, input int axis_param_get,
      input logic [7:0] est, input logic [31:0] evl, input bit vchk);
      logic [63:0] body;
      logic [7:0] sum;
      bit ok;
      int n;
      body = {adr, ins, typ, bnk, val};
      sum = 8'h00;
      for (n = 0; n < 8; n++) begin
         sum += body[63-8*n -: 8];
      end
      pach_host_inst.send_frame({body, sum ^ sumx}, axis_param_get, ok);
      chk("bytes taken", 1, ok);
      if (!ok) begin
         summarize();
      end
      n = 0;
      while (reply_valid_out !== 1'b1 && n < 12) begin
         @(negedge mclk_in);
         n++;
      end
      if (est == 8'h00) begin
         chk("no reply", 1, n >= 12);
      end else if (n >= 12) begin
         chk("reply seen", 1, 0);
         summarize();
      end else if (n != 1) begin
         chk("reply latency", 32'd1, n);
      end else if (est == ANY_ERR) begin
         chk("error status", 1, reply_status_out !== ST_OK);
      end else begin
         chk("status", est, reply_status_out);
         if (vchk) begin
            chk("value", evl, reply_value_out);
         end
      end
   endtask

   // ******************************************************
   // Scenarios
   // ******************************************************
   task automatic t_axis;
      cmd(A, INS_GLOBAL_SET, 8'h05, BANK_USER, 32'h1234_5678, 0, 0, ST_OK, 0, 0);
      cmd(A, INS_GLOBAL_GET, 8'h05, BANK_USER, 32'hFFFF_0000, 0, 0, ST_OK, 32'h1234_5678, 1);
      chk("accu global get", 32'h1234_5678, accu_out);
      cmd(A, INS_AXIS_SET, 8'h04, AXIS_MOTOR, 32'h0000_C800, 0, 0, ST_OK, 0, 0);
      cmd(A, INS_AXIS_SET, 8'h0F, AXIS_MOTOR, 32'hFFFF_FFFF, 0, 2, ST_OK, 0, 0);
      cmd(A, INS_AXIS_GET, 8'h04, AXIS_MOTOR, 32'h0, 0, 0, ST_OK, 32'h0000_C800, 1);
      cmd(A, INS_AXIS_GET, 8'h0F, AXIS_MOTOR, 32'h0, 0, 1, ST_OK, 32'hFFFF_FFFF, 1);
      chk("accu direct get", 32'h1234_5678, accu_out);
      standalone_in = 1'b1;
      cmd(A, INS_AXIS_GET, 8'h04, AXIS_MOTOR, 32'h0, 0, 0, ST_OK, 32'h0000_C800, 1);
      chk("accu program get", 32'h0000_C800, accu_out);
      standalone_in = 1'b0;
      $display("test axis set and get done");
   endtask

   task automatic t_store;
      cmd(A, INS_AXIS_SET, 8'h03, AXIS_MOTOR, 32'hAAAA_5555, 0, 0, ST_OK, 0, 0);
      cmd(A, INS_AXIS_STORE, 8'h03, AXIS_MOTOR, 32'hDEAD_BEEF, 0, 0, ST_OK, VAL_ZERO, 1);
      cmd(A, INS_AXIS_SET, 8'h03, AXIS_MOTOR, 32'h1111_2222, 0, 0, ST_OK, 0, 0);
      cmd(A, INS_AXIS_RESTORE, 8'h03, AXIS_MOTOR, 32'h0000_0001, 0, 0, ST_OK, VAL_ZERO, 1);
      cmd(A, INS_AXIS_GET, 8'h03, AXIS_MOTOR, 32'h0, 0, 0, ST_OK, 32'hAAAA_5555, 1);
      // Working value only; must not survive the next reset
      cmd(A, INS_AXIS_SET, 8'h03, AXIS_MOTOR, 32'h3333_4444, 0, 0, ST_OK, 0, 0);
      $display("test axis store and restore done");
   endtask

   task automatic t_global;
      logic [7:0] banks [3];
      int i;
      banks = '{BANK_SETTINGS, BANK_USER, BANK_IRQ};
      for (i = 0; i < 3; i++) begin
         cmd(A, INS_GLOBAL_SET, 8'h07, banks[i], {banks[i], 24'h00C0DE}, 0, 0, ST_OK, 0, 0);
         cmd(A, INS_GLOBAL_GET, 8'h07, banks[i], 32'h0, 0, 0, ST_OK, {banks[i], 24'h00C0DE}, 1);
         chk("accu bank get", {banks[i], 24'h00C0DE}, accu_out);
      end
      cmd(A, INS_GLOBAL_STORE, 8'h07, BANK_USER, 32'h0, 0, 0, ST_OK, 0, 0);
      $display("test global banks done");
   endtask

   task automatic t_errors;
      logic [7:0] ins [6];
      logic [7:0] typ [6];
      logic [7:0] bnk [6];
      logic [7:0] sx [6];
      logic [7:0] est [6];
      int i;
      ins = '{INS_AXIS_SET, 8'h0C, INS_AXIS_SET, INS_AXIS_SET, INS_GLOBAL_SET, INS_GLOBAL_STORE};
      typ = '{8'h04, 8'h04, 8'h10, 8'h04, 8'h04, 8'h04};
      bnk = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, BANK_SETTINGS};
      sx = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      est = '{ST_BAD_SUM, ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_BANK, ST_BAD_BANK, ST_BAD_BANK};
      for (i = 0; i < 6; i++) begin
         cmd(A, ins[i], typ[i], bnk[i], 32'hDEAD_BEEF, sx[i], 0, est[i], 0, 0);
      end
      cmd(8'h7E, INS_AXIS_SET, 8'h04, AXIS_MOTOR, 32'hDEAD_BEEF, 0, 0, 8'h00, 0, 0);
      cmd(A, INS_AXIS_GET, 8'h04, AXIS_MOTOR, 32'h0, 0, 0, ST_OK, 32'h0000_C800, 1);
      $display("test refused frames done");
   endtask

   task automatic t_restored;
      cmd(A, INS_AXIS_GET, 8'h03, AXIS_MOTOR, 32'h0, 0, 0, ST_OK, 32'hAAAA_5555, 1);
      cmd(A, INS_GLOBAL_GET, 8'h07, BANK_SETTINGS, 32'h0, 0, 0, ST_OK, 32'h0000_C0DE, 1);
      cmd(A, INS_GLOBAL_GET, 8'h07, BANK_USER, 32'h0, 0, 0, ST_OK, 32'h0200_C0DE, 1);
      cmd(A, INS_GLOBAL_GET, 8'h07, BANK_IRQ, 32'h0, 0, 0, ST_OK, 32'h0, 1);
      $display("test power-up restore done");
   endtask

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial begin
      boot();
      t_axis();
      t_store();
      t_global();
      t_errors();
      boot();
      t_restored();
      summarize();
   end
endmodule // pach_top_tb
